// file: udlrc_pkg.sv
// Constants and types shared by the up-down and latched run control block
//
// Summary of operation
// - Raising up-down enable while ramping stops the ramp and holds the present frequency.
// - With run and up-down enable active, the frequency rises while up is asserted.
// - Releasing up stops the rise and holds the frequency constant.
// - Releasing down stops the fall and holds the frequency constant.
// - Up and down asserted together hold constant speed.
// - At constant speed the frequency is stored on run drop, fault trip or power loss.
// - On run return, power return or fault recovery the stored frequency is resumed.
// - The clear input at constant speed erases the stored frequency and up-down setting.
// - In three-wire mode a momentary run input is latched after the button is released.
// - Three-wire command pulses shorter than 1 ms are not accepted as commands.
// - In three-wire mode forward and reverse active together stop operation.
// - Up and down are ignored and the normal reference followed unless up-down enable is on.
`default_nettype none
package udlrc_pkg;
   localparam int CLK_MHZ = 10;
   // Least pulse width accepted in three-wire mode, rounded up to cycles
   localparam int MIN_PULSE_US = 1000;
   localparam int MIN_PULSE_CYC = MIN_PULSE_US * CLK_MHZ;
   // Time between frequency steps while up or down is held, rounded down
   localparam int UD_STEP_US = 1000;
   localparam int UD_STEP_CYC = UD_STEP_US * CLK_MHZ;
   localparam int CNT_W = 16;
   localparam int FREQ_W = 16;
   localparam logic [FREQ_W-1:0] FREQ_MAX = 16'h4E20;
   localparam logic [FREQ_W-1:0] FREQ_STEP = 16'h0001;
   localparam logic [FREQ_W-1:0] FREQ_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   // Terminal function codes the configuration assigns
   localparam logic [7:0] FN_THREE_WIRE = 8'h0E;
   localparam logic [7:0] FN_UP = 8'h11;
   localparam logic [7:0] FN_DOWN = 8'h12;
   localparam logic [7:0] FN_UD_CLEAR = 8'h14;
   localparam logic [1:0] SRC_TWO_WIRE = 2'h1;

   typedef enum logic [1:0] {
      UDC_FOLLOW = 2'b00,
      UDC_HOLD = 2'b01,
      UDC_UP = 2'b10,
      UDC_DOWN = 2'b11
   } udlrc_mode_e;
endpackage : udlrc_pkg
`default_nettype wire

// file: udlrc_pulse_qual.sv
// Minimum-width qualifier for one push-button input
`timescale 1ns/1ps
`default_nettype none
module udlrc_pulse_qual
   import udlrc_pkg::*;
#(
   parameter int MIN_CYCLES = MIN_PULSE_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Raw and qualified level
   input wire logic sig_i,
   output logic qual_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic qual;
   } udlrc_qual_s;

   udlrc_qual_s st;
   udlrc_qual_s next_st;

   always_comb begin
      next_st = st;
      if (!sig_i) begin
         next_st.cnt = CNT_RST;
         next_st.qual = 1'b0;
      end else if (st.cnt < CNT_W'(MIN_CYCLES - 1)) begin
         next_st.cnt = st.cnt + 16'h0001;
      end else begin
         next_st.qual = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign qual_o = st.qual;

   a_short_pulse: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(qual_o) |-> $past(sig_i) && st.cnt == CNT_W'(MIN_CYCLES - 1))
      else $error("qualified level rose before the least pulse width");
endmodule : udlrc_pulse_qual
`default_nettype wire

// file: udlrc_freq_store.sv
// Saved up-down frequency word with its valid flag
`timescale 1ns/1ps
`default_nettype none
module udlrc_freq_store
   import udlrc_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Save and erase
   input wire logic save_i,
   input wire logic clear_i,
   input wire logic [FREQ_W-1:0] data_i,
   // Stored word
   output logic [FREQ_W-1:0] data_o,
   output logic valid_o
);
   typedef struct packed {
      logic [FREQ_W-1:0] data;
      logic valid;
   } udlrc_store_s;

   udlrc_store_s st;
   udlrc_store_s next_st;

   always_comb begin
      next_st = st;
      // A save in the clearing cycle wins so a fresh value is not lost
      if (save_i) begin
         next_st.data = data_i;
         next_st.valid = 1'b1;
      end else if (clear_i) begin
         next_st.data = FREQ_RST;
         next_st.valid = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign data_o = st.data;
   assign valid_o = st.valid;

   a_save_wins: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      save_i |=> valid_o && data_o == $past(data_i))
      else $error("saved frequency not stored");
endmodule : udlrc_freq_store
`default_nettype wire

// file: udlrc_top.sv
// Up-down frequency adjustment and three-wire run latch
`timescale 1ns/1ps
`default_nettype none
module udlrc_top
   import udlrc_pkg::*;
#(
   parameter int MIN_PULSE_CYCLES = MIN_PULSE_CYC,
   parameter int UD_STEP_CYCLES = UD_STEP_CYC
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rstn_i,
   // Configuration
   input wire logic three_wire_mode_i,
   input wire logic save_enable_i,
   // Run terminals
   input wire logic forward_run_command_i,
   input wire logic reverse_run_command_i,
   input wire logic stop_button_n_i,
   // Up-down terminals
   input wire logic updown_enable_i,
   input wire logic up_i,
   input wire logic down_i,
   input wire logic ud_clear_i,
   // Drive state
   input wire logic fault_trip_i,
   input wire logic power_fail_i,
   input wire logic [FREQ_W-1:0] normal_freq_ref_i,
   input wire logic [FREQ_W-1:0] present_freq_i,
   // Run commands
   output logic run_forward_o,
   output logic run_reverse_o,
   // Frequency reference
   output logic [FREQ_W-1:0] freq_ref_o,
   output logic ramp_hold_o,
   output logic ud_active_o,
   // Saved frequency
   output logic [FREQ_W-1:0] saved_freq_o,
   output logic saved_valid_o
);
   typedef struct packed {
      udlrc_mode_e mode;
      logic [FREQ_W-1:0] freq;
      logic [CNT_W-1:0] step_cnt;
      logic fwd_latch;
      logic rev_latch;
      logic run_q;
      logic fault_q;
      logic pwr_q;
      logic ud_en_q;
      logic [FREQ_W-1:0] freq_ref;
      logic hold;
   } udlrc_state_s;

   udlrc_state_s st;
   udlrc_state_s next_st;

   logic [1:0] raw_cmd;
   logic [1:0] qual_cmd;
   logic run_now;
   logic save_now;
   logic clear_now;
   logic restore_now;
   logic step_tick;
   logic [FREQ_W-1:0] store_freq;
   logic store_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Three-wire pulse qualification

   assign raw_cmd = {reverse_run_command_i, forward_run_command_i};

   for (genvar g = 0; g < 2; g++) begin : g_qual
      udlrc_pulse_qual #(
         .MIN_CYCLES(MIN_PULSE_CYCLES)
      ) u_qual (
         .mclk_i(mclk_i),
         .rstn_i(rstn_i),
         .sig_i(raw_cmd[g]),
         .qual_o(qual_cmd[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Saved frequency

   udlrc_freq_store u_store (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .save_i(save_now),
      .clear_i(clear_now),
      .data_i(st.freq),
      .data_o(store_freq),
      .valid_o(store_valid)
   );

   function automatic logic [FREQ_W-1:0] step_up(input logic [FREQ_W-1:0] f);
      step_up = (f >= FREQ_MAX - FREQ_STEP) ? FREQ_MAX : f + FREQ_STEP;
   endfunction : step_up

   function automatic logic [FREQ_W-1:0] step_down(input logic [FREQ_W-1:0] f);
      step_down = (f <= FREQ_STEP) ? FREQ_RST : f - FREQ_STEP;
   endfunction : step_down

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;
      if (three_wire_mode_i) begin
         if (!stop_button_n_i || (qual_cmd[0] && qual_cmd[1])) begin
            next_st.fwd_latch = 1'b0;
            next_st.rev_latch = 1'b0;
         end else if (qual_cmd[0]) begin
            next_st.fwd_latch = 1'b1;
            next_st.rev_latch = 1'b0;
         end else if (qual_cmd[1]) begin
            next_st.fwd_latch = 1'b0;
            next_st.rev_latch = 1'b1;
         end
      end else begin
         // Two-wire mode refuses both directions at once rather than pick one
         next_st.fwd_latch = forward_run_command_i && !reverse_run_command_i;
         next_st.rev_latch = reverse_run_command_i && !forward_run_command_i;
      end
      run_now = next_st.fwd_latch || next_st.rev_latch;
      next_st.run_q = run_now;
      next_st.fault_q = fault_trip_i;
      next_st.pwr_q = power_fail_i;
      next_st.ud_en_q = updown_enable_i;

      // store on stop, trip or power loss
      save_now = save_enable_i && st.mode == UDC_HOLD &&
                 ((st.run_q && !run_now) || (fault_trip_i && !st.fault_q) ||
                  (power_fail_i && !st.pwr_q));
      clear_now = ud_clear_i && st.mode == UDC_HOLD && run_now;
      restore_now = store_valid && updown_enable_i && st.ud_en_q &&
                    ((run_now && !st.run_q) || (!fault_trip_i && st.fault_q) ||
                     (!power_fail_i && st.pwr_q));
      step_tick = st.step_cnt == CNT_W'(UD_STEP_CYCLES - 1);

      if (st.mode == UDC_UP || st.mode == UDC_DOWN) begin
         next_st.step_cnt = step_tick ? CNT_RST : st.step_cnt + 16'h0001;
      end else begin
         next_st.step_cnt = CNT_RST;
      end

      if (!updown_enable_i) begin
         next_st.mode = UDC_FOLLOW;
         next_st.freq = normal_freq_ref_i;
      // freeze the ramp where it stands
      end else if (!st.ud_en_q) begin
         next_st.mode = UDC_HOLD;
         next_st.freq = present_freq_i;
      end else if (clear_now) begin
         next_st.mode = UDC_HOLD;
         next_st.freq = FREQ_RST;
      end else if (restore_now) begin
         next_st.mode = UDC_HOLD;
         next_st.freq = store_freq;
      end else if (!run_now) begin
         next_st.mode = UDC_HOLD;
      end else begin
         case ({up_i, down_i})
            2'b10: begin
               next_st.mode = UDC_UP;
               if (st.mode == UDC_UP && step_tick) begin
                  next_st.freq = step_up(st.freq);
               end
            end
            2'b01: begin
               next_st.mode = UDC_DOWN;
               if (st.mode == UDC_DOWN && step_tick) begin
                  next_st.freq = step_down(st.freq);
               end
            end
            2'b00, 2'b11: begin
               next_st.mode = UDC_HOLD;
            end
            default: begin
               next_st.mode = UDC_HOLD;
            end
         endcase
      end

      next_st.freq_ref = next_st.freq;
      next_st.hold = next_st.mode == UDC_HOLD;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign run_forward_o = st.fwd_latch;
   assign run_reverse_o = st.rev_latch;
   assign freq_ref_o = st.freq_ref;
   assign ramp_hold_o = st.hold;
   assign ud_active_o = st.ud_en_q;
   assign saved_freq_o = store_freq;
   assign saved_valid_o = store_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_follow_normal: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !updown_enable_i |=> freq_ref_o == $past(normal_freq_ref_i) && !ramp_hold_o)
      else $error("reference did not follow normal source");

   a_enable_freeze: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      updown_enable_i && !st.ud_en_q |=> ramp_hold_o && freq_ref_o == $past(present_freq_i))
      else $error("ramp not frozen on up-down enable");

   a_up_raises: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_UP && step_tick && up_i && !down_i && run_now && st.ud_en_q &&
      updown_enable_i && !restore_now && st.freq < FREQ_MAX - FREQ_STEP
      |=> freq_ref_o == $past(st.freq) + FREQ_STEP)
      else $error("frequency did not rise by one step");

   a_up_clamp: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_UP && step_tick && up_i && !down_i && run_now && st.ud_en_q &&
      updown_enable_i && !restore_now && st.freq >= FREQ_MAX - FREQ_STEP
      |=> freq_ref_o == FREQ_MAX)
      else $error("frequency not clamped at the top");

   a_up_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_UP && !up_i && !down_i && updown_enable_i && !restore_now
      |=> ramp_hold_o && freq_ref_o == $past(st.freq))
      else $error("frequency not held after up release");

   a_down_lowers: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_DOWN && step_tick && down_i && !up_i && run_now && st.ud_en_q &&
      updown_enable_i && !restore_now && st.freq > FREQ_STEP
      |=> freq_ref_o == $past(st.freq) - FREQ_STEP)
      else $error("frequency did not fall by one step");

   a_down_clamp: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_DOWN && step_tick && down_i && !up_i && run_now && st.ud_en_q &&
      updown_enable_i && !restore_now && st.freq <= FREQ_STEP
      |=> freq_ref_o == FREQ_RST)
      else $error("frequency not clamped at zero");

   a_down_release: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      st.mode == UDC_DOWN && !down_i && !up_i && updown_enable_i && !restore_now
      |=> ramp_hold_o && freq_ref_o == $past(st.freq))
      else $error("frequency not held after down release");

   a_both_hold: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      (up_i && down_i && updown_enable_i && st.ud_en_q) [*2]
      |-> ramp_hold_o && $stable(freq_ref_o))
      else $error("up and down together changed speed");

   a_store_freq: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      save_enable_i && st.mode == UDC_HOLD && st.run_q && !run_now
      |=> saved_valid_o && saved_freq_o == $past(st.freq))
      else $error("frequency not saved on run drop");

   a_resume_freq: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      restore_now && !clear_now |=> freq_ref_o == $past(store_freq))
      else $error("stored frequency not resumed");

   a_clear_erase: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      clear_now && !save_now && updown_enable_i && st.ud_en_q
      |=> !saved_valid_o && freq_ref_o == FREQ_RST)
      else $error("clear did not erase the stored frequency");

   ////////////////////////////////////////////////////////////////////////////
   // Run latch checks

   a_latch_run: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      three_wire_mode_i && st.fwd_latch && stop_button_n_i && !qual_cmd[1]
      |=> run_forward_o)
      else $error("latched run dropped without stop");

   a_latch_rev: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      three_wire_mode_i && st.rev_latch && stop_button_n_i && !qual_cmd[0]
      |=> run_reverse_o)
      else $error("latched reverse run dropped without stop");

   a_two_wire_follow: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      !three_wire_mode_i |=>
      run_forward_o == $past(forward_run_command_i && !reverse_run_command_i) &&
      run_reverse_o == $past(reverse_run_command_i && !forward_run_command_i))
      else $error("two-wire run did not follow the terminals");

   a_fwd_pulse_width: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(run_forward_o) && $past(three_wire_mode_i) |-> $past(qual_cmd[0]))
      else $error("forward run latched from an unqualified press");

   a_rev_pulse_width: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      $rose(run_reverse_o) && $past(three_wire_mode_i) |-> $past(qual_cmd[1]))
      else $error("reverse run latched from an unqualified press");

   a_both_stop: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      three_wire_mode_i && qual_cmd[0] && qual_cmd[1] |=> !run_forward_o && !run_reverse_o)
      else $error("run kept with both directions active");

   a_stop_clears: assert property (@(posedge mclk_i) disable iff (!rstn_i)
      three_wire_mode_i && !stop_button_n_i |=> !run_forward_o && !run_reverse_o)
      else $error("run kept while stop pressed");
endmodule : udlrc_top
`default_nettype wire

// file: udlrc_terminal_model.sv
// Push-button and switch terminals that feed the run command inputs
`timescale 1ns/1ps
`default_nettype none
module udlrc_terminal_model (
   // Clock
   input wire logic mclk_i,
   // Terminal levels
   output logic three_wire_mode_o,
   output logic forward_run_command_o,
   output logic reverse_run_command_o,
   output logic stop_button_n_o
);
   // Released buttons fall to the pull-down level, the stop contact rests closed
   initial begin
      three_wire_mode_o = 1'b0;
      forward_run_command_o = 1'b0;
      reverse_run_command_o = 1'b0;
      stop_button_n_o = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Callers enter these tasks at a falling edge only
   // three-wire source with latch function
   task automatic set_mode(input logic three);
      three_wire_mode_o = three;
   endtask : set_mode

   task automatic set_run(input logic fwd, input logic rev);
      forward_run_command_o = fwd;
      reverse_run_command_o = rev;
   endtask : set_run

   task automatic press(input logic fwd, input logic rev, input int n);
      forward_run_command_o = fwd;
      reverse_run_command_o = rev;
      repeat (n) @(negedge mclk_i);
      forward_run_command_o = 1'b0;
      reverse_run_command_o = 1'b0;
   endtask : press

   task automatic stop_press();
      stop_button_n_o = 1'b0;
      @(negedge mclk_i);
      stop_button_n_o = 1'b1;
   endtask : stop_press
endmodule : udlrc_terminal_model
`default_nettype wire

// file: udlrc_tb_top.sv
// Self-checking bench for the up-down and latched run control block
`timescale 1ns/1ps
`default_nettype none
module udlrc_tb_top;
   import udlrc_pkg::*;
   localparam int MINP = 4;
   localparam int STEP = 3;
   localparam int S_FREQ = 0, S_FWD = 1, S_REV = 2, S_HOLD = 3;
   localparam int S_SAVED = 4, S_VALID = 5, S_UDACT = 6, S_SAME = 7;
   typedef struct {int sel; logic [FREQ_W-1:0] lo; logic [FREQ_W-1:0] hi;} udlrc_note_s;

   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic save_en = 1'b0, ud_en = 1'b0, up = 1'b0, down = 1'b0, clr = 1'b0;
   logic fault = 1'b0, pfail = 1'b0;
   logic [FREQ_W-1:0] normal = 16'h0000, present = 16'h0000, val, act, last_freq;
   wire logic tw, fwd, rev, stop_n;
   logic run_f, run_r, hold, udact, svalid;
   logic [FREQ_W-1:0] fref, sfreq;
   udlrc_note_s note_q[$];
   udlrc_note_s cur;
   int n_fail = 0, num_checks = 0, cycles = 0, seed = 97;

   always #50 mclk_i = ~mclk_i;

   udlrc_terminal_model model (.mclk_i(mclk_i), .three_wire_mode_o(tw),
      .forward_run_command_o(fwd), .reverse_run_command_o(rev), .stop_button_n_o(stop_n));

   udlrc_top #(.MIN_PULSE_CYCLES(MINP), .UD_STEP_CYCLES(STEP)) DUT (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .three_wire_mode_i(tw), .save_enable_i(save_en),
      .forward_run_command_i(fwd), .reverse_run_command_i(rev), .stop_button_n_i(stop_n),
      .updown_enable_i(ud_en), .up_i(up), .down_i(down), .ud_clear_i(clr),
      .fault_trip_i(fault), .power_fail_i(pfail), .normal_freq_ref_i(normal),
      .present_freq_i(present), .run_forward_o(run_f), .run_reverse_o(run_r),
      .freq_ref_o(fref), .ramp_hold_o(hold), .ud_active_o(udact),
      .saved_freq_o(sfreq), .saved_valid_o(svalid));

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : cyc

   task automatic chk(input int sel, input logic [FREQ_W-1:0] lo, input logic [FREQ_W-1:0] hi);
      note_q.push_back('{sel, lo, hi});
   endtask : chk

   function automatic logic [FREQ_W-1:0] rnd_freq();
      rnd_freq = FREQ_W'($unsigned($random(seed)) % 32'h4E21);
   endfunction : rnd_freq

   task automatic test_done(input string name);
      wait (note_q.size() == 0);
      $display("test %s done", name);
   endtask : test_done

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////
   // Monitor: outputs are settled at the falling edge where a note is queued
   always begin
      wait (note_q.size() > 0);
      cur = note_q.pop_front();
      case (cur.sel)
         S_FWD: act = {15'h0000, run_f};
         S_REV: act = {15'h0000, run_r};
         S_HOLD: act = {15'h0000, hold};
         S_SAVED: act = sfreq;
         S_VALID: act = {15'h0000, svalid};
         S_UDACT: act = {15'h0000, udact};
         default: act = fref;
      endcase
      // A hold check compares against the last frequency that was checked
      if (cur.sel == S_SAME) begin
         cur.lo = last_freq;
         cur.hi = last_freq;
      end
      if (cur.sel == S_FREQ) begin
         last_freq = act;
      end
      num_checks++;
      if (!((cur.lo == cur.hi) ? (act === cur.lo) : (((act >= cur.lo) && (act <= cur.hi)) === 1'b1))) begin
         n_fail++;
         $display("unexpected value at %0t: got %h expected %h..%h", $time, act, cur.lo, cur.hi);
      end
   end

   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         $display("unexpected hang at %0t: cycles %h expected %h", $time, cycles, 0);
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(12);
      rstn_i = 1'b1;
      cyc(1);
      chk(S_FREQ, 16'h0000, 16'h0000);
      chk(S_FWD, 16'h0000, 16'h0000);
      chk(S_VALID, 16'h0000, 16'h0000);
      test_done("reset");
      normal = rnd_freq();
      // up and down ride on their own terminal inputs
      up = 1'b1;
      cyc(2);
      chk(S_FREQ, normal, normal);
      chk(S_UDACT, 16'h0000, 16'h0000);
      up = 1'b0;
      model.set_run(1'b1, 1'b0);
      present = 16'h0005;
      ud_en = 1'b1;
      cyc(1);
      chk(S_FWD, 16'h0001, 16'h0001);
      chk(S_HOLD, 16'h0001, 16'h0001);
      chk(S_FREQ, 16'h0005, 16'h0005);
      present = rnd_freq();
      cyc(3);
      chk(S_SAME, 16'h0000, 16'h0000);
      chk(S_UDACT, 16'h0001, 16'h0001);
      down = 1'b1;
      cyc(30);
      chk(S_FREQ, 16'h0000, 16'h0000);
      chk(S_HOLD, 16'h0000, 16'h0000);
      down = 1'b0;
      cyc(1);
      chk(S_HOLD, 16'h0001, 16'h0001);
      cyc(3);
      chk(S_SAME, 16'h0000, 16'h0000);
      test_done("down");
      ud_en = 1'b0;
      normal = rnd_freq();
      cyc(2);
      chk(S_FREQ, normal, normal);
      ud_en = 1'b1;
      present = 16'h4E10;
      cyc(1);
      chk(S_FREQ, 16'h4E10, 16'h4E10);
      up = 1'b1;
      cyc(1 + 5 * STEP);
      chk(S_FREQ, 16'h4E13, 16'h4E16);
      cyc(60);
      chk(S_FREQ, FREQ_MAX, FREQ_MAX);
      up = 1'b0;
      cyc(1);
      chk(S_HOLD, 16'h0001, 16'h0001);
      cyc(4);
      chk(S_SAME, 16'h0000, 16'h0000);
      up = 1'b1;
      down = 1'b1;
      cyc(10);
      chk(S_HOLD, 16'h0001, 16'h0001);
      chk(S_SAME, 16'h0000, 16'h0000);
      up = 1'b0;
      down = 1'b0;
      test_done("up");
      save_en = 1'b1;
      for (int k = 0; k < 3; k++) begin
         val = rnd_freq();
         ud_en = 1'b0;
         cyc(1);
         ud_en = 1'b1;
         present = val;
         cyc(1);
         chk(S_FREQ, val, val);
         present = rnd_freq();
         case (k)
            0: model.set_run(1'b0, 1'b0);
            1: fault = 1'b1;
            default: pfail = 1'b1;
         endcase
         cyc(1);
         chk(S_VALID, 16'h0001, 16'h0001);
         chk(S_SAVED, val, val);
         ud_en = 1'b0;
         cyc(1);
         // Move off the saved value so that the resume is visible
         ud_en = 1'b1;
         present = rnd_freq();
         cyc(1);
         model.set_run(1'b1, 1'b0);
         fault = 1'b0;
         pfail = 1'b0;
         cyc(1);
         chk(S_FREQ, val, val);
      end
      test_done("save");
      cyc(2);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      chk(S_VALID, 16'h0000, 16'h0000);
      chk(S_FREQ, 16'h0000, 16'h0000);
      test_done("clear");
      model.set_run(1'b0, 1'b1);
      cyc(1);
      chk(S_REV, 16'h0001, 16'h0001);
      chk(S_FWD, 16'h0000, 16'h0000);
      model.set_run(1'b1, 1'b1);
      cyc(1);
      chk(S_REV, 16'h0000, 16'h0000);
      chk(S_FWD, 16'h0000, 16'h0000);
      test_done("two_wire");
      ud_en = 1'b0;
      model.set_run(1'b0, 1'b0);
      // Drain the qualifiers in two-wire mode, or the old press would latch
      cyc(1);
      model.set_mode(1'b1);
      cyc(2);
      chk(S_FWD, 16'h0000, 16'h0000);
      model.press(1'b1, 1'b0, MINP - 1);
      cyc(3);
      chk(S_FWD, 16'h0000, 16'h0000);
      model.press(1'b1, 1'b0, MINP);
      cyc(3);
      chk(S_FWD, 16'h0001, 16'h0001);
      model.stop_press();
      cyc(1);
      chk(S_FWD, 16'h0000, 16'h0000);
      model.press(1'b0, 1'b1, MINP);
      cyc(3);
      chk(S_REV, 16'h0001, 16'h0001);
      model.press(1'b1, 1'b1, MINP + 3);
      chk(S_FWD, 16'h0000, 16'h0000);
      chk(S_REV, 16'h0000, 16'h0000);
      test_done("three_wire");
      end_sim();
   end
endmodule : udlrc_tb_top
`default_nettype wire
